//--- logic/nav_track_sleep_control_regs.sv
`timescale 1ns/1ps
`include "nav_track_params.svh"
// Contract
// [RULE_01] X displacement is the X motion count times the 16-bit X scale.
// [RULE_02] Y displacement is the Y motion count times the 16-bit Y scale.
// [RULE_03] Scale writes land any time but are used from the next boundary.
// [RULE_04] With sleep switching disabled no automatic sleep transition occurs.
// [RULE_05] With track switching disabled no automatic track transition occurs.
// [RULE_06] With switching disabled only the forced request changes state.
// [RULE_07] The sleep track-select field picks integration times only in sleep.
// [RULE_08] Software programs a track-select that matches the frame rate.
// [RULE_09] Every state machine transition raises the state-change event.
// [RULE_10] Mask bits 3,2,1,0 gate state, boost, supply and laser events.
// [RULE_11] Both edges of the boost undervoltage level raise its event.
// [RULE_12] The filtered supply signal rises when power goes to wired.
// [RULE_13] The filtered supply signal falls when power goes to wireless.
// [RULE_14] Each edge of the filtered supply signal raises its event.
// [RULE_15] Laser on past its limit raises the error level and its event.
// [RULE_16] A forced request moves state at the boundary and then self-clears.
// [RULE_17] Lift uses upper and lower 8-bit thresholds as hysteresis.
module nav_track_sleep_control_regs (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic blockBoundary,
   input wire logic [15:0] xCount,
   input wire logic [15:0] yCount,
   input wire logic autoSwitchReq,
   input wire logic [3:0] autoMode,
   input wire logic [7:0] surfaceMetric,
   input wire logic boostUnderVoltPin,
   input wire logic supplyWiredPin,
   input wire logic laserOnPin,
   output logic [15:0] dxOut,
   output logic [15:0] dyOut,
   output logic [3:0] trackMode,
   output logic sleepActive,
   output logic [2:0] integrationSel,
   output logic liftDetected,
   output logic [7:0] powerDspTrim,
   output logic supplyFiltered,
   output logic laserError,
   output logic state_change_irq,
   output logic boost_undervolt_irq,
   output logic supply_source_irq,
   output logic laser_on_timeout_irq
);

   // ----------------------------------------------------------------
   // Register bus
   // ----------------------------------------------------------------
   logic [7:0] dxScaleLo, dxScaleHi, dyScaleLo, dyScaleHi;
   logic [7:0] swCtrl, forceCtrl, liftUpper, liftLower, eventMask;
   logic [15:0] xBuf, yBuf;
   logic setupPhase, wrAccess;
   logic forceDone;
   logic [31:0] next_prdata;
   logic boostSync, boostPrev;
   localparam logic [15:0] RstScale = `RST_SCALE;

   function automatic logic addrMapped(input logic [7:0] a);
      return a <= `OFF_STATUS && a[1:0] == 2'b00;
   endfunction : addrMapped

   function automatic logic wrHit(input logic en, input logic [7:0] a,
                                  input logic [7:0] off);
      return en && a == off;
   endfunction : wrHit

   assign setupPhase = psel && !penable;
   assign wrAccess = psel && penable && pwrite && addrMapped(paddr);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addrMapped(paddr);

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         dxScaleLo <= RstScale[7:0];
         dxScaleHi <= RstScale[15:8];
         dyScaleLo <= RstScale[7:0];
         dyScaleHi <= RstScale[15:8];
         swCtrl <= `RST_BYTE;
         liftUpper <= `RST_LIFT_UP;
         liftLower <= `RST_BYTE;
         eventMask <= `RST_BYTE;
         powerDspTrim <= `RST_BYTE;
      end else begin
         if (wrHit(wrAccess, paddr, `OFF_DX_LO)) dxScaleLo <= pwdata[7:0];
         if (wrHit(wrAccess, paddr, `OFF_DX_HI)) dxScaleHi <= pwdata[7:0];
         if (wrHit(wrAccess, paddr, `OFF_DY_LO)) dyScaleLo <= pwdata[7:0];
         if (wrHit(wrAccess, paddr, `OFF_DY_HI)) dyScaleHi <= pwdata[7:0];
         if (wrHit(wrAccess, paddr, `OFF_SW_CTRL)) swCtrl <= pwdata[7:0] & 8'h1F;
         if (wrHit(wrAccess, paddr, `OFF_LIFT_UP)) liftUpper <= pwdata[7:0];
         if (wrHit(wrAccess, paddr, `OFF_LIFT_LO)) liftLower <= pwdata[7:0];
         if (wrHit(wrAccess, paddr, `OFF_MASK)) eventMask <= pwdata[7:0] & 8'h0F;
         if (wrHit(wrAccess, paddr, `OFF_TRIM)) powerDspTrim <= pwdata[7:0];
      end
   end

   // Software write of the request wins over the hardware self-clear
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         forceCtrl <= `RST_BYTE;
      end else if (wrHit(wrAccess, paddr, `OFF_FORCE)) begin
         forceCtrl <= pwdata[7:0] & 8'h1F;
      end else if (forceDone) begin
         forceCtrl[`FS_EN] <= 1'b0; // see [RULE_16]
      end
   end

   always_comb begin
      next_prdata = 32'h0000_0000;
      case (paddr)
         `OFF_XBUF_HI: next_prdata[7:0] = xBuf[15:8];
         `OFF_YBUF_LO: next_prdata[7:0] = yBuf[7:0];
         `OFF_YBUF_HI: next_prdata[7:0] = yBuf[15:8];
         `OFF_DX_LO: next_prdata[7:0] = dxScaleLo;
         `OFF_DX_HI: next_prdata[7:0] = dxScaleHi;
         `OFF_DY_LO: next_prdata[7:0] = dyScaleLo;
         `OFF_DY_HI: next_prdata[7:0] = dyScaleHi;
         `OFF_SW_CTRL: next_prdata[7:0] = swCtrl;
         `OFF_FORCE: next_prdata[7:0] = forceCtrl;
         `OFF_TRIM: next_prdata[7:0] = powerDspTrim;
         `OFF_LIFT_UP: next_prdata[7:0] = liftUpper;
         `OFF_LIFT_LO: next_prdata[7:0] = liftLower;
         `OFF_MASK: next_prdata[7:0] = eventMask;
         `OFF_STATUS: next_prdata[7:0] = {boostPrev, laserError,
                                          supplyFiltered, liftDetected,
                                          trackMode};
         default: next_prdata = 32'h0000_0000;
      endcase
   end

   // Read data is captured in the setup cycle, ready in the access cycle
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         prdata <= 32'h0000_0000;
      end else if (setupPhase && !pwrite) begin
         prdata <= next_prdata;
      end
   end

   // ----------------------------------------------------------------
   // Scaling
   // ----------------------------------------------------------------
   logic [15:0] dxScaleAct, dyScaleAct;
   logic [31:0] dxProd, dyProd;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         dxScaleAct <= `RST_SCALE;
         dyScaleAct <= `RST_SCALE;
      end else if (blockBoundary) begin
         dxScaleAct <= {dxScaleHi, dxScaleLo}; // see [RULE_03]
         dyScaleAct <= {dyScaleHi, dyScaleLo}; // see [RULE_03]
      end
   end

   assign dxProd = xCount * dxScaleAct;
   assign dyProd = yCount * dyScaleAct;

   // Scale is 8.8 fixed point; counts are buffered at the same boundary
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         dxOut <= 16'h0000;
         dyOut <= 16'h0000;
         xBuf <= 16'h0000;
         yBuf <= 16'h0000;
      end else if (blockBoundary) begin
         dxOut <= dxProd[23:8]; // see [RULE_01]
         dyOut <= dyProd[23:8]; // see [RULE_02]
         xBuf <= xCount;
         yBuf <= yCount;
      end
   end

   // ----------------------------------------------------------------
   // Tracking state machine
   // ----------------------------------------------------------------
   nav_track_pkg::trk_phase_t phase, next_phase;
   logic [2:0] modeIdx, next_modeIdx;
   logic forceReq, autoAllowed, sleepInvolved, stateChanged;
   nav_track_pkg::mode_code_t forceMode;

   assign forceReq = forceCtrl[`FS_EN];
   assign forceMode = forceCtrl[`FS_MODE_LSB +: 4];
   assign sleepInvolved = autoMode[3] || phase == nav_track_pkg::PH_SLEEP;
   assign autoAllowed = sleepInvolved ? !swCtrl[`SW_DIS_SLEEP] // see [RULE_04]
                                      : !swCtrl[`SW_DIS_TRACK]; // see [RULE_05]
   assign forceDone = blockBoundary && forceReq;

   always_comb begin
      next_phase = phase;
      next_modeIdx = modeIdx;
      case (phase)
         nav_track_pkg::PH_TRACK, nav_track_pkg::PH_SLEEP: begin
            if (forceDone) begin // see [RULE_06]
               next_phase = forceMode[3] ? nav_track_pkg::PH_SLEEP
                                         : nav_track_pkg::PH_TRACK;
               next_modeIdx = forceMode[2:0]; // see [RULE_16]
            end else if (blockBoundary && autoSwitchReq && autoAllowed) begin
               next_phase = autoMode[3] ? nav_track_pkg::PH_SLEEP
                                        : nav_track_pkg::PH_TRACK;
               next_modeIdx = autoMode[2:0];
            end
         end
         default: begin
            next_phase = nav_track_pkg::PH_TRACK;
            next_modeIdx = 3'h0;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         phase <= nav_track_pkg::PH_TRACK;
         modeIdx <= 3'h0;
      end else begin
         phase <= next_phase;
         modeIdx <= next_modeIdx;
      end
   end

   assign trackMode = {phase == nav_track_pkg::PH_SLEEP, modeIdx};
   assign sleepActive = phase == nav_track_pkg::PH_SLEEP;
   assign stateChanged = next_phase != phase || next_modeIdx != modeIdx;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         integrationSel <= 3'h0;
      end else if (next_phase == nav_track_pkg::PH_SLEEP) begin
         integrationSel <= swCtrl[`SW_SEL_LSB +: 3]; // see [RULE_07]
      end else begin
         integrationSel <= next_modeIdx;
      end
   end

   // ----------------------------------------------------------------
   // Lift detection
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         liftDetected <= 1'b0;
      end else if (surfaceMetric > liftUpper) begin
         liftDetected <= 1'b1; // see [RULE_17]
      end else if (surfaceMetric < liftLower) begin
         liftDetected <= 1'b0; // see [RULE_17]
      end
   end

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [2:0] pinRaw, pinMeta, pinSync;

   assign pinRaw = {laserOnPin, supplyWiredPin, boostUnderVoltPin};

   generate
      for (genvar i = 0; i < 3; i++) begin : g_sync
         always_ff @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
               pinMeta[i] <= 1'b0;
               pinSync[i] <= 1'b0;
            end else begin
               pinMeta[i] <= pinRaw[i];
               pinSync[i] <= pinMeta[i];
            end
         end
      end
   endgenerate

   assign boostSync = pinSync[0];

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         boostPrev <= 1'b0;
      end else begin
         boostPrev <= boostSync;
      end
   end

   // ----------------------------------------------------------------
   // Supply source filter
   // ----------------------------------------------------------------
   localparam logic [11:0] SupplyCyc = 12'(`SUPPLY_FILTER_CYC);
   logic [11:0] supplyCnt;
   logic supplyEdge;

   // Level must differ for the whole filter time before it is taken
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         supplyCnt <= 12'h000;
         supplyFiltered <= 1'b0;
      end else if (pinSync[1] == supplyFiltered) begin
         supplyCnt <= 12'h000;
      end else if (supplyCnt == SupplyCyc - 12'h001) begin
         supplyCnt <= 12'h000;
         supplyFiltered <= pinSync[1]; // see [RULE_12] [RULE_13]
      end else begin
         supplyCnt <= supplyCnt + 12'h001;
      end
   end

   assign supplyEdge = pinSync[1] != supplyFiltered
                       && supplyCnt == SupplyCyc - 12'h001;

   // ----------------------------------------------------------------
   // Laser on-time watchdog
   // ----------------------------------------------------------------
   localparam logic [11:0] LaserCyc = 12'(`LASER_MAX_ON_CYC);
   logic [11:0] laserCnt;
   logic laserRise;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         laserCnt <= 12'h000;
         laserError <= 1'b0;
      end else if (!pinSync[2]) begin
         laserCnt <= 12'h000;
         laserError <= 1'b0;
      end else if (laserCnt != LaserCyc) begin
         laserCnt <= laserCnt + 12'h001;
      end else begin
         laserError <= 1'b1; // see [RULE_15]
      end
   end

   assign laserRise = pinSync[2] && laserCnt == LaserCyc && !laserError;

   // ----------------------------------------------------------------
   // Masked event pulses
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_change_irq <= 1'b0;
         boost_undervolt_irq <= 1'b0;
         supply_source_irq <= 1'b0;
         laser_on_timeout_irq <= 1'b0;
      end else begin
         state_change_irq <= stateChanged
                             && eventMask[`MSK_STATE]; // see [RULE_09] [RULE_10]
         boost_undervolt_irq <= (boostSync != boostPrev)
                                && eventMask[`MSK_BOOST]; // see [RULE_11]
         supply_source_irq <= supplyEdge
                              && eventMask[`MSK_SUPPLY]; // see [RULE_14]
         laser_on_timeout_irq <= laserRise
                                 && eventMask[`MSK_LASER]; // see [RULE_15]
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   sequence s_forceAtBoundary;
      blockBoundary && forceReq && !wrAccess;
   endsequence

   sequence s_forceApplied;
      trackMode == $past(forceMode) && !forceReq;
   endsequence

   AST_SCALE_AT_BOUNDARY: assert property ( // see [RULE_03]
      !blockBoundary |=> $stable(dxScaleAct) && $stable(dyScaleAct))
      else $error("scale changed off a block boundary");

   AST_DX_PRODUCT: assert property ( // see [RULE_01]
      blockBoundary |=> dxOut ==
         16'(({16'h0000, $past(xCount)} * $past(dxScaleAct)) >> 8))
      else $error("dx output is not the scaled count");

   AST_DY_PRODUCT: assert property ( // see [RULE_02]
      blockBoundary |=> dyOut ==
         16'(({16'h0000, $past(yCount)} * $past(dyScaleAct)) >> 8))
      else $error("dy output is not the scaled count");

   AST_NO_AUTO_SLEEP: assert property ( // see [RULE_04]
      swCtrl[`SW_DIS_SLEEP] && !forceDone && sleepActive |=> $stable(trackMode))
      else $error("sleep state changed while sleep switching disabled");

   AST_NO_AUTO_TRACK: assert property ( // see [RULE_05]
      swCtrl[`SW_DIS_TRACK] && !sleepActive && !autoMode[3] && !forceDone
      |=> $stable(trackMode))
      else $error("state changed with switching disabled and no force");

   AST_FORCE_SELFCLEAR: assert property ( // see [RULE_16]
      s_forceAtBoundary |=> s_forceApplied)
      else $error("forced request not applied or not cleared");

   AST_INT_SELECT: assert property ( // see [RULE_07]
      sleepActive |=> !sleepActive ||
      integrationSel == $past(swCtrl[`SW_SEL_LSB +: 3]))
      else $error("sleep integration select not taken from the field");

   AST_STATE_EVENT: assert property ( // see [RULE_09]
      $past(eventMask[`MSK_STATE]) && !$stable(trackMode)
      |-> state_change_irq)
      else $error("state change without event");

   AST_MASK_GATES: assert property ( // see [RULE_10]
      !$past(eventMask[`MSK_BOOST]) |-> !boost_undervolt_irq)
      else $error("masked boost event leaked");

   AST_LIFT_HYST: assert property ( // see [RULE_17]
      surfaceMetric > liftUpper |=> liftDetected)
      else $error("lift not detected above upper level");

   AST_LASER_TIMEOUT: assert property ( // see [RULE_15]
      laserRise && eventMask[`MSK_LASER]
      |=> laserError && laser_on_timeout_irq)
      else $error("laser error did not rise");

endmodule : nav_track_sleep_control_regs

//--- pkg/nav_track_params.svh
`ifndef NAV_TRACK_PARAMS_SVH
`define NAV_TRACK_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFF_XBUF_HI 8'h00
`define OFF_YBUF_LO 8'h04
`define OFF_YBUF_HI 8'h08
`define OFF_DX_LO 8'h0C
`define OFF_DX_HI 8'h10
`define OFF_DY_LO 8'h14
`define OFF_DY_HI 8'h18
`define OFF_SW_CTRL 8'h1C
`define OFF_FORCE 8'h20
`define OFF_TRIM 8'h24
`define OFF_LIFT_UP 8'h28
`define OFF_LIFT_LO 8'h2C
`define OFF_MASK 8'h30
`define OFF_STATUS 8'h34

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SW_DIS_TRACK 0
`define SW_DIS_SLEEP 1
`define SW_SEL_LSB 2
`define FS_EN 0
`define FS_MODE_LSB 1
`define MSK_LASER 0
`define MSK_SUPPLY 1
`define MSK_BOOST 2
`define MSK_STATE 3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_SCALE 16'h0100
`define RST_LIFT_UP 8'hFF
`define RST_MODE 4'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_MHZ 25
`define LASER_MAX_ON_US 100
`define LASER_MAX_ON_CYC (`LASER_MAX_ON_US * `CLK_MHZ)
`define SUPPLY_FILTER_NS 1000
`define SUPPLY_FILTER_CYC ((`SUPPLY_FILTER_NS * `CLK_MHZ) / 1000)

`endif

//--- pkg/nav_track_pkg.sv
package nav_track_pkg;

   // Phase of the tracking state machine
   typedef enum logic [1:0] {
      PH_TRACK = 2'b01,
      PH_SLEEP = 2'b10
   } trk_phase_t;

   // Mode code: bit 3 set for sleep, bits 2:0 the mode index
   typedef logic [3:0] mode_code_t;

endpackage : nav_track_pkg

//--- tb/nav_track_sleep_control_regs_tb_top.sv
`timescale 1ns/1ps
`include "nav_track_params.svh"
module nav_track_sleep_control_regs_tb_top;
   logic coreClk = 1'b0;
   logic rstB;
   logic psel, penable, pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic pready, pslverr, perr;
   logic blockBoundary, autoSwitchReq;
   logic [15:0] xCount, yCount, dxOut, dyOut;
   logic [3:0] autoMode, trackMode;
   logic [7:0] surfaceMetric, powerDspTrim;
   logic boostUnderVoltPin, supplyWiredPin, laserOnPin;
   logic sleepActive, liftDetected, supplyFiltered, laserError;
   logic [2:0] integrationSel;
   logic stateIrq, boostIrq, supplyIrq, laserIrq;
   logic [15:0] rs = `RST_SCALE;
   int nFail = 0;
   int checks = 0;
   int nSc = 0;
   int nBo = 0;
   int nSu = 0;
   int nLa = 0;

   nav_track_sleep_control_regs nav_track_sleep_control_regs_i (
      .core_clk(coreClk), .rst_b(rstB), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .blockBoundary(blockBoundary),
      .xCount(xCount), .yCount(yCount), .autoSwitchReq(autoSwitchReq),
      .autoMode(autoMode), .surfaceMetric(surfaceMetric),
      .boostUnderVoltPin(boostUnderVoltPin),
      .supplyWiredPin(supplyWiredPin), .laserOnPin(laserOnPin),
      .dxOut(dxOut), .dyOut(dyOut), .trackMode(trackMode),
      .sleepActive(sleepActive), .integrationSel(integrationSel),
      .liftDetected(liftDetected), .powerDspTrim(powerDspTrim),
      .supplyFiltered(supplyFiltered), .laserError(laserError),
      .state_change_irq(stateIrq), .boost_undervolt_irq(boostIrq),
      .supply_source_irq(supplyIrq), .laser_on_timeout_irq(laserIrq));

   always #20 coreClk = ~coreClk;

   // -----------------------------------------------------------
   // Event pulse counters
   // -----------------------------------------------------------
   always @(posedge coreClk) begin
      if (stateIrq === 1'b1) nSc <= nSc + 1;
      if (boostIrq === 1'b1) nBo <= nBo + 1;
      if (supplyIrq === 1'b1) nSu <= nSu + 1;
      if (laserIrq === 1'b1) nLa <= nLa + 1;
   end

   // -----------------------------------------------------------
   // Reporting, check, bus and stimulus tasks
   // -----------------------------------------------------------
   task summarize;
      $display("checks %0d failures %0d", checks, nFail);
      if (nFail == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : summarize

   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         nFail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge coreClk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge coreClk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge coreClk);
         n++;
      end while (pready !== 1'b1);
      if (n != 1) chk("waitStates", 32'h1, n);
      rdat = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer

   task wr(input logic [7:0] a, input logic [7:0] d);
      xfer(1'b1, a, {24'h000000, d});
   endtask : wr

   task rchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
      xfer(1'b0, a, 32'h00000000);
      chk(nm, {24'h000000, exp}, rdat);
   endtask : rchk

   task settle(input int n);
      repeat (n) @(posedge coreClk);
      @(negedge coreClk);
   endtask : settle

   task bnd(input logic req, input logic [3:0] m);
      @(posedge coreClk);
      blockBoundary <= 1'b1;
      autoSwitchReq <= req;
      autoMode <= m;
      @(posedge coreClk);
      blockBoundary <= 1'b0;
      autoSwitchReq <= 1'b0;
      settle(2);
   endtask : bnd

   task pins(input logic b, input logic s, input logic l, input logic [7:0] m);
      @(posedge coreClk);
      boostUnderVoltPin <= b;
      supplyWiredPin <= s;
      laserOnPin <= l;
      surfaceMetric <= m;
   endtask : pins

   // -----------------------------------------------------------
   // Watchdog
   // -----------------------------------------------------------
   initial begin
      repeat (20000) @(posedge coreClk);
      nFail++;
      summarize();
   end

   // -----------------------------------------------------------
   // Tests
   // -----------------------------------------------------------
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {blockBoundary, autoSwitchReq, autoMode, surfaceMetric} = '0;
      {boostUnderVoltPin, supplyWiredPin, laserOnPin} = '0;
      xCount = 16'h0100;
      yCount = 16'h0100;
      rstB = 1'b0;
      repeat (4) @(posedge coreClk);
      rstB <= 1'b1;
      rchk("dxLoReset", `OFF_DX_LO, rs[7:0]);
      rchk("dxHiReset", `OFF_DX_HI, rs[15:8]);
      rchk("liftUpReset", `OFF_LIFT_UP, `RST_LIFT_UP);
      rchk("maskReset", `OFF_MASK, 8'h00);
      chk("modeReset", 32'h0, {28'h0, trackMode});
      xfer(1'b0, 8'h38, 32'h00000000);
      chk("unmappedErr", 32'h1, {31'h0, perr});
      chk("unmappedData", 32'h0, rdat);
      wr(`OFF_TRIM, 8'hA5);
      rchk("trimRead", `OFF_TRIM, 8'hA5);
      chk("trimOut", 32'hA5, {24'h0, powerDspTrim});
      bnd(1'b0, 4'h0);
      chk("dxUnity", 32'h0100, {16'h0, dxOut});
      chk("dyUnity", 32'h0100, {16'h0, dyOut});
      rchk("xBufHi", `OFF_XBUF_HI, 8'h01);
      rchk("yBufLo", `OFF_YBUF_LO, 8'h00);
      rchk("yBufHi", `OFF_YBUF_HI, 8'h01);
      wr(`OFF_DX_LO, 8'h00);
      wr(`OFF_DX_HI, 8'h02);
      wr(`OFF_DY_LO, 8'h80);
      wr(`OFF_DY_HI, 8'h00);
      settle(3);
      chk("dxHeld", 32'h0100, {16'h0, dxOut});
      bnd(1'b0, 4'h0);
      bnd(1'b0, 4'h0);
      chk("dxScaled", 32'h0200, {16'h0, dxOut});
      chk("dyScaled", 32'h0080, {16'h0, dyOut});
      wr(`OFF_MASK, 8'h0F);
      wr(`OFF_FORCE, 8'h07);
      bnd(1'b0, 4'h0);
      chk("forcedMode", 32'h3, {28'h0, trackMode});
      rchk("forceCleared", `OFF_FORCE, 8'h06);
      chk("stateEvt1", 32'd1, nSc);
      wr(`OFF_SW_CTRL, 8'h15);
      bnd(1'b1, 4'h2);
      chk("trackLocked", 32'h3, {28'h0, trackMode});
      bnd(1'b1, 4'h9);
      chk("toSleep", 32'h9, {28'h0, trackMode});
      chk("sleepFlag", 32'h1, {31'h0, sleepActive});
      chk("sleepSel", 32'h5, {29'h0, integrationSel});
      chk("stateEvt2", 32'd2, nSc);
      wr(`OFF_SW_CTRL, 8'h16);
      bnd(1'b1, 4'hA);
      chk("sleepLocked", 32'h9, {28'h0, trackMode});
      bnd(1'b1, 4'h2);
      chk("wakeLocked", 32'h9, {28'h0, trackMode});
      wr(`OFF_MASK, 8'h07);
      wr(`OFF_FORCE, 8'h03);
      bnd(1'b0, 4'h0);
      chk("forceOverride", 32'h1, {28'h0, trackMode});
      chk("trackSel", 32'h1, {29'h0, integrationSel});
      chk("stateMasked", 32'd2, nSc);
      wr(`OFF_SW_CTRL, 8'h00);
      wr(`OFF_MASK, 8'h0F);
      pins(1'b1, 1'b0, 1'b0, 8'h00);
      settle(10);
      chk("boostRise", 32'd1, nBo);
      pins(1'b0, 1'b0, 1'b0, 8'h00);
      settle(10);
      chk("boostFall", 32'd2, nBo);
      wr(`OFF_MASK, 8'h0B);
      pins(1'b1, 1'b0, 1'b0, 8'h00);
      settle(10);
      chk("boostMasked", 32'd2, nBo);
      pins(1'b1, 1'b1, 1'b0, 8'h00);
      settle(10);
      pins(1'b1, 1'b0, 1'b0, 8'h00);
      settle(40);
      chk("supplyGlitch", 32'd0, nSu + supplyFiltered);
      pins(1'b1, 1'b1, 1'b0, 8'h00);
      settle(40);
      chk("supplyWired", 32'h1, {31'h0, supplyFiltered});
      chk("supplyEvtUp", 32'd1, nSu);
      pins(1'b1, 1'b0, 1'b0, 8'h00);
      settle(40);
      chk("supplyCell", 32'h0, {31'h0, supplyFiltered});
      chk("supplyEvtDn", 32'd2, nSu);
      pins(1'b1, 1'b0, 1'b1, 8'h00);
      settle(2400);
      chk("laserEarly", 32'h0, {31'h0, laserError});
      settle(200);
      chk("laserLate", 32'h1, {31'h0, laserError});
      chk("laserEvt", 32'd1, nLa);
      wr(`OFF_LIFT_UP, 8'h80);
      wr(`OFF_LIFT_LO, 8'h40);
      pins(1'b1, 1'b0, 1'b0, 8'h90);
      settle(4);
      chk("liftSet", 32'h1, {31'h0, liftDetected});
      rchk("status", `OFF_STATUS, 8'h91);
      pins(1'b1, 1'b0, 1'b0, 8'h60);
      settle(4);
      chk("liftHold", 32'h1, {31'h0, liftDetected});
      pins(1'b1, 1'b0, 1'b0, 8'h30);
      settle(4);
      chk("liftClear", 32'h0, {31'h0, liftDetected});
      summarize();
   end
endmodule : nav_track_sleep_control_regs_tb_top
